// ===== rtl/queue_status_dma_mode_ctrl.sv
// buffer chain status and host transfer mode control register bank
// assumes chain state inputs come from logic on clock_i; pause comes from a pin
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ns
module queue_status_dma_mode_ctrl
  import qstat_pkg::*;
#(
  parameter bit STATIC_CHAIN = 1'b0,
  parameter int CNT_W = 7,
  parameter int PTR_W = 7,
  parameter int ADDR_W = 10
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // chain state
  input wire logic [CNT_W-1:0] block_count_i,
  input wire logic [PTR_W-1:0] first_ptr_i,
  input wire logic [PTR_W-1:0] last_packet_end_value_i,
  input wire logic packet_end_marker_i,
  input wire logic pause_i,
  // transfer routing
  output logic dma_read_mode_o,
  output logic dma_write_mode_o,
  output logic [ADDR_W-1:0] dma_target_o,
  output logic chain_data_ready_o,
  // interrupt
  output logic irq_o
);

  initial
  begin
    if (CNT_W != 7 || PTR_W != 7 || ADDR_W != 10)
      $error("widths must match the register layout");
  end

  logic pause_s1_r;
  logic pause_s2_r;
  logic rdy_r;
  logic pmask_r;
  logic [1:0] mode_r;
  logic [CNT_W-1:0] thr_r;
  logic rdmode_r;
  logic wrmode_r;
  logic [ADDR_W-1:0] taddr_r;
  logic [NUM_EVT-1:0] ist_r;
  logic [NUM_EVT-1:0] imsk_r;
  logic ack_r;
  logic [31:0] readdata_r;
  logic above;
  logic below;
  logic rdy_nxt;
  logic cond;
  logic [31:0] status_word;
  logic [31:0] dma_word;
  logic [NUM_EVT-1:0] evt;
  logic rd_take;
  logic wr_take;
  logic [ADDR_W-1:0] wr_target;

  // one-cycle wait on every access keeps read data registered
  assign waitrequest_o = (read_i | write_i) & ~ack_r;
  assign rd_take = read_i & ack_r;
  assign wr_take = write_i & ack_r;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= (read_i | write_i) & ~ack_r;
  end

  // pause is a pin: two stages before use
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pause_s1_r <= 1'b0;
      pause_s2_r <= 1'b0;
    end
    else
    begin
      pause_s1_r <= pause_i;
      pause_s2_r <= pause_s1_r;
    end
  end

  // static chains carry no count, so compare flags read zero there
  assign above = !STATIC_CHAIN && (block_count_i > thr_r);
  assign below = !STATIC_CHAIN && (block_count_i < thr_r);

  always_comb
  begin
    unique case (mode_r)
      MODE_FIRST: cond = (first_ptr_i != '0);
      MODE_ABOVE: cond = above;
      MODE_LAST_PACKET_END_VALUE: cond = (last_packet_end_value_i != '0);
      MODE_EITHER: cond = above | (last_packet_end_value_i != '0);
    endcase
  end

  // pause holds the flag where it stands rather than forcing it low
  always_comb
  begin
    rdy_nxt = rdy_r;
    if (!pause_s2_r || pmask_r)
      rdy_nxt = cond;
    if (wr_take && address_i == STATUS_OFS && !writedata_i[RDY_BIT] && !cond)
      rdy_nxt = 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rdy_r <= 1'b0;
    else
      rdy_r <= rdy_nxt;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pmask_r <= 1'b0;
      mode_r <= MODE_FIRST;
      thr_r <= '0;
    end
    else if (wr_take && address_i == STATUS_OFS)
    begin
      pmask_r <= writedata_i[PMASK_BIT];
      if (!STATIC_CHAIN)
      begin
        mode_r <= writedata_i[MODE_HI:MODE_LO];
        thr_r <= writedata_i[THR_HI:THR_LO];
      end
    end
  end

  always_comb
  begin
    status_word = RESET_VAL;
    status_word[RDY_BIT] = rdy_r;
    status_word[PMASK_BIT] = pmask_r;
    if (!STATIC_CHAIN)
    begin
      status_word[MODE_HI:MODE_LO] = mode_r;
      status_word[EOP_BIT] = packet_end_marker_i;
      status_word[ABOVE_BIT] = above;
      status_word[BELOW_BIT] = below;
      status_word[THR_HI:THR_LO] = thr_r;
      status_word[CNT_HI:0] = block_count_i;
    end
  end

  // a write loads read mode but can only raise write mode; only a read ends it
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdmode_r <= 1'b0;
      wrmode_r <= 1'b0;
      taddr_r <= '0;
    end
    else if (wr_take && address_i == DMACTL_OFS)
    begin
      rdmode_r <= writedata_i[RDMODE_BIT];
      wrmode_r <= wrmode_r | writedata_i[WRMODE_BIT];
      taddr_r <= writedata_i[TADDR_HI:0];
    end
    else if (rd_take && address_i == DMACTL_OFS)
      wrmode_r <= 1'b0;
  end

  always_comb
  begin
    dma_word = RESET_VAL;
    dma_word[RDMODE_BIT] = rdmode_r;
    dma_word[WRMODE_BIT] = wrmode_r;
    dma_word[TADDR_HI:0] = taddr_r;
  end

  assign dma_read_mode_o = rdmode_r;
  assign dma_write_mode_o = wrmode_r;
  assign dma_target_o = taddr_r;
  assign wr_target = writedata_i[TADDR_HI:0];
  assign chain_data_ready_o = rdy_r;

  // events: data-ready rise, above rise, below rise
  logic above_d_r;
  logic below_d_r;
  assign evt = {below & ~below_d_r, above & ~above_d_r, rdy_nxt & ~rdy_r};
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      above_d_r <= 1'b0;
      below_d_r <= 1'b0;
    end
    else
    begin
      above_d_r <= above;
      below_d_r <= below;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++)
    begin : g_ist
      // set wins over a simultaneous write-one clear
      always_ff @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
          ist_r[gi] <= 1'b0;
        else if (evt[gi])
          ist_r[gi] <= 1'b1;
        else if (wr_take && address_i == INTST_OFS && writedata_i[gi])
          ist_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      imsk_r <= '0;
    else if (wr_take && address_i == INTMSK_OFS)
      imsk_r <= writedata_i[NUM_EVT-1:0];
  end

  assign irq_o = |(ist_r & imsk_r);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      readdata_r <= RESET_VAL;
    else if (read_i && !ack_r)
    begin
      unique case (address_i)
        STATUS_OFS: readdata_r <= status_word;
        DMACTL_OFS: readdata_r <= dma_word;
        INTST_OFS: readdata_r <= {{(32-NUM_EVT){1'b0}}, ist_r};
        INTMSK_OFS: readdata_r <= {{(32-NUM_EVT){1'b0}}, imsk_r};
        default: readdata_r <= UNMAPPED_VAL;
      endcase
    end
  end

  assign readdata_o = readdata_r;

  property p_above;
    @(posedge clock_i) disable iff (rst_i)
      (!STATIC_CHAIN && block_count_i > thr_r)
        |-> status_word[ABOVE_BIT] && !status_word[BELOW_BIT];
  endproperty
  a_above: assert property (p_above) else $error("above flag wrong");

  property p_below;
    @(posedge clock_i) disable iff (rst_i)
      (!STATIC_CHAIN && block_count_i < thr_r)
        |-> status_word[BELOW_BIT] && !status_word[ABOVE_BIT];
  endproperty
  a_below: assert property (p_below) else $error("below flag wrong");

  property p_equal;
    @(posedge clock_i) disable iff (rst_i)
      (block_count_i == thr_r) |-> !above && !below;
  endproperty
  a_equal: assert property (p_equal) else $error("equal count raised a flag");

  property p_pause;
    @(posedge clock_i) disable iff (rst_i)
      (pause_s2_r && !pmask_r && !rdy_r && !wr_take) |=> !rdy_r;
  endproperty
  a_pause: assert property (p_pause) else $error("ready set during pause");

  property p_mode0;
    @(posedge clock_i) disable iff (rst_i)
      (!pause_s2_r && mode_r == MODE_FIRST && first_ptr_i != '0) |=> rdy_r;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 00 ready missing");

  property p_rdhold;
    @(posedge clock_i) disable iff (rst_i)
      (rdmode_r && !(wr_take && address_i == DMACTL_OFS)) |=> rdmode_r;
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("read mode dropped");

  property p_wrend;
    @(posedge clock_i) disable iff (rst_i)
      (rd_take && address_i == DMACTL_OFS) |=> !wrmode_r;
  endproperty
  a_wrend: assert property (p_wrend) else $error("write mode not ended");

  property p_target;
    @(posedge clock_i) disable iff (rst_i)
      (wr_take && address_i == DMACTL_OFS) |=> dma_target_o == $past(wr_target);
  endproperty
  a_target: assert property (p_target) else $error("target address wrong");

  property p_count;
    @(posedge clock_i) disable iff (rst_i)
      !STATIC_CHAIN |-> status_word[CNT_HI:0] == block_count_i;
  endproperty
  a_count: assert property (p_count) else $error("count field wrong");

  property p_wrhold;
    @(posedge clock_i) disable iff (rst_i)
      (wrmode_r && !(rd_take && address_i == DMACTL_OFS)) |=> wrmode_r;
  endproperty
  a_wrhold: assert property (p_wrhold) else $error("write mode dropped");

  property p_mode1;
    @(posedge clock_i) disable iff (rst_i)
      (!pause_s2_r && mode_r == MODE_ABOVE && above) |=> rdy_r;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 01 ready missing");

  property p_static;
    @(posedge clock_i) disable iff (rst_i)
      STATIC_CHAIN |-> mode_r == MODE_FIRST && thr_r == '0 && !status_word[EOP_BIT]
        && !status_word[ABOVE_BIT] && !status_word[BELOW_BIT] && status_word[CNT_HI:0] == '0;
  endproperty
  a_static: assert property (p_static) else $error("static chain field live");

  property p_setwins;
    @(posedge clock_i) disable iff (rst_i)
      (evt[0] && wr_take && address_i == INTST_OFS) |=> ist_r[0];
  endproperty
  a_setwins: assert property (p_setwins) else $error("clear beat a ready event");

  c_rdmode: cover property (@(posedge clock_i) disable iff (rst_i) $rose(rdmode_r));
  c_wrmode: cover property (@(posedge clock_i) disable iff (rst_i) $fell(wrmode_r));
  c_ready: cover property (@(posedge clock_i) disable iff (rst_i) $rose(rdy_r));
  c_irq: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_o));

endmodule

// ===== rtl/qstat_pkg.sv
// constants for the buffer chain status and host transfer mode control registers
// assumes a single 100 MHz clock and an Avalon-MM register bus with waitrequest
package qstat_pkg;
  localparam logic [9:0] STATUS_OFS = 10'h01C;
  localparam logic [9:0] DMACTL_OFS = 10'h100;
  localparam logic [9:0] INTST_OFS = 10'h120;
  localparam logic [9:0] INTMSK_OFS = 10'h124;
  localparam int RDY_BIT = 31;
  localparam int PMASK_BIT = 30;
  localparam int MODE_HI = 25;
  localparam int MODE_LO = 24;
  localparam int EOP_BIT = 18;
  localparam int ABOVE_BIT = 17;
  localparam int BELOW_BIT = 16;
  localparam int THR_HI = 14;
  localparam int THR_LO = 8;
  localparam int CNT_HI = 6;
  localparam int RDMODE_BIT = 17;
  localparam int WRMODE_BIT = 16;
  localparam int TADDR_HI = 9;
  localparam int NUM_EVT = 3;
  localparam logic [1:0] MODE_FIRST = 2'h0;
  localparam logic [1:0] MODE_ABOVE = 2'h1;
  localparam logic [1:0] MODE_LAST_PACKET_END_VALUE = 2'h2;
  localparam logic [1:0] MODE_EITHER = 2'h3;
  localparam logic [31:0] RESET_VAL = 32'h00000000;
  localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;
endpackage

// ===== tb/host_model.sv
// host side avalon-mm master for the register bank
// assumes a slave on clock_i that raises waitrequest at least one cycle
`timescale 1ns/1ns
module host_model
(
  // clock
  input wire logic clock_i,
  // avalon-mm master
  output logic [9:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i
);
  initial
  begin
    address_o = 10'h000;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h00000000;
  end
  // reads of the control register end write mode; writes load read mode but can only raise write mode
  task automatic xfer(input bit wr, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    begin
      @(posedge clock_i);
      address_o <= a;
      writedata_o <= d;
      read_o <= !wr;
      write_o <= wr;
      // waitrequest and read data are both taken at the same rising edge
      @(posedge clock_i);
      while (waitrequest_i !== 1'b0)
        @(posedge clock_i);
      q = readdata_i;
      read_o <= 1'b0;
      write_o <= 1'b0;
    end
  endtask
endmodule

// ===== tb/queue_status_dma_mode_ctrl_tb_top.sv
// self-checking bench for the status and transfer mode register bank
// assumes the host model drives the bus; chain state driven here
`timescale 1ns/1ns
module queue_status_dma_mode_ctrl_tb_top;
  import qstat_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] address;
  logic rd, wr, wreq, dmr, dmw, rdy, irq, eop, pause;
  logic [31:0] wdata, rdata, q;
  logic [9:0] tgt;
  logic [6:0] cnt, thr, fptr, last_packet_end_value;
  logic [6:0] nc;
  logic [9:0] ta;
  logic [31:0] rdata_s;
  logic [1:0] m;
  logic pm, erdy;
  int failures = 0;
  int checks = 0;
  queue_status_dma_mode_ctrl i_queue_status_dma_mode_ctrl (.clock_i(clock_i), .rst_i(rst_i),
    .address_i(address), .read_i(rd), .write_i(wr), .writedata_i(wdata), .readdata_o(rdata),
    .waitrequest_o(wreq), .block_count_i(cnt), .first_ptr_i(fptr),
    .last_packet_end_value_i(last_packet_end_value), .packet_end_marker_i(eop), .pause_i(pause),
    .dma_read_mode_o(dmr), .dma_write_mode_o(dmw), .dma_target_o(tgt),
    .chain_data_ready_o(rdy), .irq_o(irq));
  host_model i_host_model (.clock_i(clock_i), .address_o(address), .read_o(rd),
    .write_o(wr), .writedata_o(wdata), .readdata_i(rdata), .waitrequest_i(wreq));
  // static chain copy shares the bus; only its read data is watched
  queue_status_dma_mode_ctrl #(.STATIC_CHAIN(1'b1)) i_queue_status_dma_mode_ctrl_static (
    .clock_i(clock_i), .rst_i(rst_i), .address_i(address), .read_i(rd), .write_i(wr),
    .writedata_i(wdata), .readdata_o(rdata_s), .waitrequest_o(), .block_count_i(cnt),
    .first_ptr_i(fptr), .last_packet_end_value_i(last_packet_end_value), .packet_end_marker_i(eop),
    .pause_i(pause), .dma_read_mode_o(), .dma_write_mode_o(), .dma_target_o(),
    .chain_data_ready_o(), .irq_o());
  initial
  begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic wrap_up;
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit w, input logic [9:0] a, input logic [31:0] d);
    i_host_model.xfer(w, a, d, q);
  endtask
  function automatic logic [31:0] exp_st(input logic [6:0] c, t, input logic e);
    exp_st = {1'b0, pm, 4'h0, m, 5'h00, e, c > t, c < t, 1'b0, t, 1'b0, c};
  endfunction
  function automatic logic exp_cond();
    case (m)
      MODE_FIRST: exp_cond = fptr != 7'h00;
      MODE_ABOVE: exp_cond = cnt > thr;
      MODE_LAST_PACKET_END_VALUE: exp_cond = last_packet_end_value != 7'h00;
      default: exp_cond = cnt > thr || last_packet_end_value != 7'h00;
    endcase
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  initial
  begin
    {cnt, thr, fptr, last_packet_end_value, eop, pause, m, pm, erdy} = '0;
    void'($urandom(32'hEE9F));
    wait_n(2);
    rst_i <= 1'b0;
    bus(0, STATUS_OFS, 32'h00000000);
    cmp(q, RESET_VAL);
    bus(0, DMACTL_OFS, 32'h00000000);
    cmp(q, RESET_VAL);
    for (int i = 0; i < 32; i++)
    begin
      // first four rounds put the threshold on the count, one round per mode
      m = 2'(i);
      pm = 1'($urandom);
      nc = 7'($urandom);
      thr = (i < 4) ? nc : 7'($urandom);
      pause <= 1'b0;
      cnt <= nc;
      fptr <= (i % 4 == 1) ? 7'h00 : 7'($urandom);
      last_packet_end_value <= (i % 4 == 2) ? 7'h00 : 7'($urandom);
      eop <= 1'($urandom);
      bus(1, STATUS_OFS, {1'b0, pm, 4'hF, m, 8'hFF, 1'b1, thr, 8'hFF});
      wait_n(4);
      erdy = exp_cond();
      cmp(rdy, erdy);
      bus(0, STATUS_OFS, 32'h00000000);
      cmp(q, {erdy, 31'h00000000} | exp_st(cnt, thr, eop));
      cmp(rdata_s & 32'h7FFFFFFF, {1'b0, pm, 30'h00000000});
      // inputs move only once the pause has passed the synchroniser
      pause <= 1'($urandom);
      wait_n(4);
      cnt <= ~cnt;
      fptr <= ~fptr;
      last_packet_end_value <= ~last_packet_end_value;
      wait_n(4);
      if (!(pause && !pm))
        erdy = exp_cond();
      cmp(rdy, erdy);
    end
    cmp(irq, 1'b0);
    pause <= 1'b0;
    cnt <= 7'h0A;
    {m, pm, thr} = {MODE_ABOVE, 1'b1, 7'h00};
    bus(1, STATUS_OFS, 32'h41000000);
    wait_n(4);
    bus(1, INTST_OFS, 32'h00000007);
    bus(1, INTMSK_OFS, 32'h00000004);
    wait_n(1);
    cmp(irq, 1'b0);
    bus(1, STATUS_OFS, 32'h41001400);
    wait_n(3);
    cmp(irq, 1'b1);
    bus(0, INTST_OFS, 32'h00000000);
    cmp(q, 32'h00000004);
    bus(1, INTMSK_OFS, 32'h00000000);
    wait_n(1);
    cmp(irq, 1'b0);
    bus(1, INTST_OFS, 32'h00000004);
    bus(0, INTST_OFS, 32'h00000000);
    cmp(q, 32'h00000000);
    // threshold back to zero: above and ready both rise, below falls
    bus(1, STATUS_OFS, 32'h41000000);
    wait_n(3);
    bus(0, INTST_OFS, 32'h00000000);
    cmp(q, 32'h00000003);
    bus(0, 10'h200, 32'h00000000);
    cmp(q, UNMAPPED_VAL);
    for (int k = 0; k < 4; k++)
    begin
      ta = 10'($urandom);
      bus(1, DMACTL_OFS, {14'h0000, 2'b10, 6'h00, ta});
      wait_n(1);
      cmp({dmr, dmw, 6'h00, tgt}, {2'b10, 6'h00, ta});
      bus(0, DMACTL_OFS, 32'h00000000);
      cmp(q, {14'h0000, 2'b10, 6'h00, ta});
      wait_n(1);
      cmp({dmr, dmw}, 2'b10);
      bus(1, DMACTL_OFS, {14'h0000, 2'b01, 16'h0155});
      wait_n(1);
      cmp({dmr, dmw, 6'h00, tgt}, {2'b01, 6'h00, 10'h155});
      // writing zero must leave write mode standing
      bus(1, DMACTL_OFS, 32'h00000000);
      wait_n(1);
      cmp({dmr, dmw}, 2'b01);
      bus(0, DMACTL_OFS, 32'h00000000);
      wait_n(1);
      cmp({dmr, dmw}, 2'b00);
    end
    wrap_up();
  end
  initial
  begin
    wait_n(4000);
    failures++;
    wrap_up();
  end
endmodule
